//--- adc_port_pkg.sv
// Shared constants and types for both ends of the converter serial port.
package adc_port_pkg;
    // Clock rates and link clock limit.
    localparam int CLK_KHZ = 125000;
    localparam int SCLK_MAX_KHZ = 3000;
    localparam int SCLK_HALF_CYC = (CLK_KHZ + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);

    // Communications byte fields.
    localparam int COMM_WEN_N_BIT = 7;
    localparam int COMM_READ_BIT = 6;
    localparam int COMM_ADDR_LSB = 0;

    // Device register addresses carried in the communications byte.
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_CTRL = 4'h1;
    localparam logic [3:0] ADDR_MAIN = 4'h2;
    localparam logic [3:0] ADDR_AUX = 4'h3;

    // Status byte bits and control register reset value.
    localparam int STAT_MAIN_RDY_BIT = 0;
    localparam int STAT_AUX_RDY_BIT = 1;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Last bit index of a transfer of 8, 16 and 24 bits.
    localparam logic [4:0] LAST_BIT_8 = 5'h07;
    localparam logic [4:0] LAST_BIT_16 = 5'h0f;
    localparam logic [4:0] LAST_BIT_24 = 5'h17;

    // Host register byte offsets on APB.
    localparam logic [11:0] HOST_CMD = 12'h000;
    localparam logic [11:0] HOST_TXDATA = 12'h004;
    localparam logic [11:0] HOST_STATUS = 12'h008;
    localparam logic [11:0] HOST_RXDATA = 12'h00c;

    // Host command and status register fields.
    localparam int CMD_COMM_LSB = 0;
    localparam int CMD_NBYTES_LSB = 8;
    localparam int CMD_GO_BIT = 16;
    localparam int HSTAT_BUSY_BIT = 0;
    localparam int HSTAT_READY_BIT = 1;

    typedef enum logic [1:0] {LNK_COMM, LNK_WRITE, LNK_READ} link_phase_t;
    typedef enum logic {HOST_IDLE, HOST_FRAME} host_state_t;
endpackage

//--- adc_link_if.sv
// Serial link between the host port and the converter device port.
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
    logic sclk;
    logic cs_n;
    logic din;
    logic din_oe;
    logic dout;
    logic dout_oe;
    logic rdy_n;
    logic receive_frame_strobe_n;
    logic transmit_frame_strobe_n;
    // Single shared data line with a pull-up, for hosts with one data wire.
    wire shared_data = din_oe ? din : (dout_oe ? dout : 1'b1);

    modport host (
        output sclk, cs_n, din, din_oe, receive_frame_strobe_n, transmit_frame_strobe_n,
        input dout, dout_oe, rdy_n
    );
    modport device (
        input sclk, cs_n, din,
        output dout, dout_oe, rdy_n
    );
endinterface
`default_nettype wire

//--- adc_sclk_gen.sv
// Serial clock divider with edge strobes for the host end.
`timescale 1ns/1ps
`default_nettype none
module adc_sclk_gen (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Control
    input wire logic i_run,
    // Clock out and strobes
    output logic o_sclk,
    output logic o_fall,
    output logic o_rise
);
    localparam logic [4:0] HALF_LAST = 5'(adc_port_pkg::SCLK_HALF_CYC - 1);

    logic [4:0] cnt_reg;
    logic sclk_reg;
    wire half_done = i_run && (cnt_reg == HALF_LAST);

    // Strobes mark the cycle at whose end the clock output toggles.
    assign o_fall = half_done && sclk_reg;
    assign o_rise = half_done && !sclk_reg;
    assign o_sclk = sclk_reg;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_reg <= 5'h00;
            sclk_reg <= 1'b1;
        end else if (!i_run) begin
            cnt_reg <= 5'h00;
            sclk_reg <= 1'b1;
        end else if (half_done) begin
            cnt_reg <= 5'h00;
            sclk_reg <= !sclk_reg;
        end else begin
            cnt_reg <= cnt_reg + 5'h01;
        end
    end
endmodule // adc_sclk_gen
`default_nettype wire

//--- adc_port_device.sv
// Device end of the converter serial port: link shifter and result flags.
//
// The register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module adc_port_device (
    // System clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Serial link, clocked by the link clock
    adc_link_if.device link,
    // Conversion results
    input wire logic [23:0] i_main_data,
    input wire logic i_main_valid,
    input wire logic [15:0] i_aux_data,
    input wire logic i_aux_valid,
    // Configuration and flags
    output logic [7:0] o_ctrl,
    output logic o_main_ready,
    output logic o_aux_ready
);
    // ---------------- Link clock domain ----------------
    adc_port_pkg::link_phase_t phase_reg, phase_next;
    logic [4:0] cnt_reg, cnt_next;
    logic [4:0] last_reg, last_next;
    logic [7:0] sh_reg, sh_next;
    logic [3:0] addr_reg, addr_next;
    logic [23:0] rd_word_reg, rd_word_next;
    logic [7:0] ctrl_reg, ctrl_next;
    logic busy_reg;
    logic clr_main_tgl_reg, clr_main_tgl_next;
    logic clr_aux_tgl_reg, clr_aux_tgl_next;
    logic dout_reg;
    logic oe_reg;

    // System domain state read by the link at decode time.
    logic [23:0] hold_reg [2];
    logic [1:0] flag_reg;

    // The select pin frames the link; tied low, framing is by bit count alone.
    wire link_rst_b = i_rst_b & ~link.cs_n;
    wire [7:0] comm_byte = {sh_reg[6:0], link.din};
    wire comm_ok = !comm_byte[adc_port_pkg::COMM_WEN_N_BIT];
    wire comm_read = comm_byte[adc_port_pkg::COMM_READ_BIT];
    wire [3:0] comm_addr = comm_byte[adc_port_pkg::COMM_ADDR_LSB +: 4];
    wire bit_last = (cnt_reg == last_reg);
    wire [4:0] out_idx = adc_port_pkg::LAST_BIT_24 - cnt_reg;
    wire read_active = (phase_reg == adc_port_pkg::LNK_READ);

    // Read words are left aligned so every length starts at bit 23.
    wire [7:0] status_byte = {6'h00, flag_reg[adc_port_pkg::STAT_AUX_RDY_BIT],
                              flag_reg[adc_port_pkg::STAT_MAIN_RDY_BIT]};
    wire sel_status = (comm_addr == adc_port_pkg::ADDR_STATUS);
    wire sel_ctrl = (comm_addr == adc_port_pkg::ADDR_CTRL);
    wire sel_main = (comm_addr == adc_port_pkg::ADDR_MAIN);
    wire sel_aux = (comm_addr == adc_port_pkg::ADDR_AUX);
    wire [23:0] read_word = sel_main ? hold_reg[0] :
                            sel_aux ? {hold_reg[1][15:0], 8'h00} :
                            sel_status ? {status_byte, 16'h0000} :
                            sel_ctrl ? {ctrl_reg, 16'h0000} : 24'h000000;
    wire [4:0] read_last = sel_main ? adc_port_pkg::LAST_BIT_24 :
                           sel_aux ? adc_port_pkg::LAST_BIT_16 : adc_port_pkg::LAST_BIT_8;

    always_comb begin
        phase_next = phase_reg;
        cnt_next = cnt_reg + 5'h01;
        last_next = last_reg;
        sh_next = sh_reg;
        addr_next = addr_reg;
        rd_word_next = rd_word_reg;
        ctrl_next = ctrl_reg;
        clr_main_tgl_next = clr_main_tgl_reg;
        clr_aux_tgl_next = clr_aux_tgl_reg;
        unique case (phase_reg)
            adc_port_pkg::LNK_COMM: begin
                sh_next = comm_byte;
                if (cnt_reg == adc_port_pkg::LAST_BIT_8) begin
                    cnt_next = 5'h00;
                    if (comm_ok) begin
                        addr_next = comm_addr;
                        if (comm_read) begin
                            // Reading a data word hands its flag back for clearing.
                            phase_next = adc_port_pkg::LNK_READ;
                            rd_word_next = read_word;
                            last_next = read_last;
                            clr_main_tgl_next = clr_main_tgl_reg ^ sel_main;
                            clr_aux_tgl_next = clr_aux_tgl_reg ^ sel_aux;
                        end else begin
                            phase_next = adc_port_pkg::LNK_WRITE;
                            last_next = adc_port_pkg::LAST_BIT_8;
                        end
                    end
                end
            end
            adc_port_pkg::LNK_WRITE: begin
                sh_next = comm_byte;
                if (bit_last) begin
                    cnt_next = 5'h00;
                    phase_next = adc_port_pkg::LNK_COMM;
                    if (addr_reg == adc_port_pkg::ADDR_CTRL) begin
                        ctrl_next = comm_byte;
                    end
                end
            end
            adc_port_pkg::LNK_READ: begin
                // The input line is left out of every update here.
                if (bit_last) begin
                    cnt_next = 5'h00;
                    phase_next = adc_port_pkg::LNK_COMM;
                end
            end
            default: begin
                cnt_next = 5'h00;
                phase_next = adc_port_pkg::LNK_COMM;
            end
        endcase
    end

    // Input bits are taken on the rising edge of the link clock.
    always_ff @(posedge link.sclk or negedge link_rst_b) begin
        if (!link_rst_b) begin
            phase_reg <= adc_port_pkg::LNK_COMM;
            cnt_reg <= 5'h00;
            last_reg <= adc_port_pkg::LAST_BIT_8;
            sh_reg <= 8'h00;
            addr_reg <= 4'h0;
            rd_word_reg <= 24'h000000;
            busy_reg <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            cnt_reg <= cnt_next;
            last_reg <= last_next;
            sh_reg <= sh_next;
            addr_reg <= addr_next;
            rd_word_reg <= rd_word_next;
            busy_reg <= !(phase_next == adc_port_pkg::LNK_COMM && cnt_next == 5'h00);
        end
    end

    // Settings and toggles survive the select going high.
    always_ff @(posedge link.sclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_reg <= adc_port_pkg::CTRL_RESET;
            clr_main_tgl_reg <= 1'b0;
            clr_aux_tgl_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            clr_main_tgl_reg <= clr_main_tgl_next;
            clr_aux_tgl_reg <= clr_aux_tgl_next;
        end
    end

    // Output bits change on the falling edge, half a period before sampling.
    always_ff @(negedge link.sclk or negedge link_rst_b) begin
        if (!link_rst_b) begin
            dout_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else begin
            dout_reg <= rd_word_reg[out_idx];
            oe_reg <= read_active;
        end
    end

    // The enable drops at the last rising edge, not at the next falling one.
    assign link.dout_oe = oe_reg & read_active;
    assign link.dout = dout_reg & oe_reg & read_active;

    // ---------------- System clock domain ----------------
    // Busy and clear toggles are events; the control byte is quasi-static.
    logic [10:0] sync1_reg;
    logic [10:0] sync2_reg;
    logic [1:0] tgl_prev_reg;
    logic rdy_n_reg;
    logic [23:0] res_in [2];
    logic [1:0] res_valid;
    logic [23:0] pend_reg [2];
    logic [1:0] pend_v_reg;

    wire [10:0] cross_in = {ctrl_reg, clr_aux_tgl_reg, clr_main_tgl_reg, busy_reg};
    wire link_busy = sync2_reg[0];
    wire [1:0] clr_evt = sync2_reg[2:1] ^ tgl_prev_reg;

    assign res_in[0] = i_main_data;
    assign res_in[1] = {8'h00, i_aux_data};
    assign res_valid = {i_aux_valid, i_main_valid};

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync1_reg <= 11'h000;
            sync2_reg <= 11'h000;
            tgl_prev_reg <= 2'h0;
            rdy_n_reg <= 1'b1;
        end else begin
            sync1_reg <= cross_in;
            sync2_reg <= sync1_reg;
            tgl_prev_reg <= sync2_reg[2:1];
            rdy_n_reg <= ~(|flag_reg);
        end
    end

    // A result waits in its pending slot until no frame is under way, so the
    // link never samples a word in the middle of its update.
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        wire load = pend_v_reg[ch] && !link_busy;
        always_ff @(posedge i_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                pend_reg[ch] <= 24'h000000;
                pend_v_reg[ch] <= 1'b0;
                hold_reg[ch] <= 24'h000000;
                flag_reg[ch] <= 1'b0;
            end else begin
                if (res_valid[ch]) begin
                    pend_reg[ch] <= res_in[ch];
                end
                pend_v_reg[ch] <= res_valid[ch] || (pend_v_reg[ch] && link_busy);
                if (load) begin
                    hold_reg[ch] <= pend_reg[ch];
                end
                // A new result in the clearing cycle keeps the flag set.
                flag_reg[ch] <= load || (flag_reg[ch] && !clr_evt[ch]);
            end
        end
    end

    assign link.rdy_n = rdy_n_reg;
    assign o_ctrl = sync2_reg[10:3];
    assign o_main_ready = flag_reg[0];
    assign o_aux_ready = flag_reg[1];
endmodule // adc_port_device
`default_nettype wire

//--- adc_port_host.sv
// Host end of the converter serial port, ordered by software over APB.
`timescale 1ns/1ps
`default_nettype none
module adc_port_host (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Serial link
    adc_link_if.host link
);
    adc_port_pkg::host_state_t state_reg;
    logic [7:0] comm_reg;
    logic [1:0] nbytes_reg;
    logic [23:0] txdata_reg;
    logic [23:0] rx_reg;
    logic [31:0] tx_sh_reg;
    logic [5:0] bit_cnt_reg;
    logic [5:0] bit_total_reg;
    logic din_reg;
    logic pready_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic rise_d_reg;
    logic [1:0] dout_sync_reg;
    logic [1:0] rdy_sync_reg;
    logic sclk_fall;
    logic sclk_rise;

    wire frame = (state_reg == adc_port_pkg::HOST_FRAME);
    wire is_read = comm_reg[adc_port_pkg::COMM_READ_BIT];
    wire in_comm = (bit_cnt_reg < 6'h08);

    adc_sclk_gen u_sclk (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_run(frame),
        .o_sclk(link.sclk),
        .o_fall(sclk_fall),
        .o_rise(sclk_rise)
    );

    // APB decode: no wait states; read data comes from a flop loaded in the setup cycle.
    wire setup = i_psel && !i_penable;
    wire access = i_psel && i_penable && pready_reg;
    wire sel_cmd = (i_paddr == adc_port_pkg::HOST_CMD);
    wire sel_tx = (i_paddr == adc_port_pkg::HOST_TXDATA);
    wire sel_stat = (i_paddr == adc_port_pkg::HOST_STATUS);
    wire sel_rx = (i_paddr == adc_port_pkg::HOST_RXDATA);
    wire mapped = sel_cmd || sel_tx || sel_stat || sel_rx;
    wire wr_cmd = access && i_pwrite && sel_cmd;
    wire wr_tx = access && i_pwrite && sel_tx && !frame;
    // A go request during a frame is dropped.
    wire go = wr_cmd && i_pwdata[adc_port_pkg::CMD_GO_BIT] && !frame;
    wire [1:0] go_nbytes = i_pwdata[adc_port_pkg::CMD_NBYTES_LSB +: 2];
    wire [7:0] go_comm = i_pwdata[adc_port_pkg::CMD_COMM_LSB +: 8];
    wire [31:0] status_word = {30'h0, ~rdy_sync_reg[1], frame};
    wire [31:0] read_mux = sel_cmd ? {22'h0, nbytes_reg, comm_reg} :
                           sel_tx ? {8'h00, txdata_reg} :
                           sel_stat ? status_word :
                           sel_rx ? {8'h00, rx_reg} : 32'h00000000;

    // Data bytes go out most significant first, left aligned after the command.
    wire [23:0] tx_aligned = (go_nbytes == 2'h1) ? {txdata_reg[7:0], 16'h0000} :
                             (go_nbytes == 2'h2) ? {txdata_reg[15:0], 8'h00} : txdata_reg;
    wire [5:0] go_total = {1'b0, go_nbytes, 3'h0} + 6'h08;
    // Bits are counted one cycle after each rising edge, so select and the data
    // enable never move at the edge on which the device samples the last bit.
    wire last_rise = rise_d_reg && (bit_cnt_reg == bit_total_reg - 6'h01);

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
            pslverr_reg <= 1'b0;
            rise_d_reg <= 1'b0;
            dout_sync_reg <= 2'h0;
            rdy_sync_reg <= 2'h3;
        end else begin
            pready_reg <= setup;
            prdata_reg <= setup ? read_mux : prdata_reg;
            pslverr_reg <= setup && !mapped;
            rise_d_reg <= sclk_rise;
            dout_sync_reg <= {dout_sync_reg[0], link.dout};
            rdy_sync_reg <= {rdy_sync_reg[0], link.rdy_n};
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            comm_reg <= 8'h00;
            nbytes_reg <= 2'h0;
            txdata_reg <= 24'h000000;
        end else begin
            if (go) begin
                comm_reg <= go_comm;
                nbytes_reg <= go_nbytes;
            end
            if (wr_tx) begin
                txdata_reg <= i_pwdata[23:0];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= adc_port_pkg::HOST_IDLE;
            tx_sh_reg <= 32'h00000000;
            bit_cnt_reg <= 6'h00;
            bit_total_reg <= 6'h08;
            din_reg <= 1'b1;
            rx_reg <= 24'h000000;
        end else if (go) begin
            state_reg <= adc_port_pkg::HOST_FRAME;
            tx_sh_reg <= {go_comm, tx_aligned};
            bit_cnt_reg <= 6'h00;
            bit_total_reg <= go_total;
            rx_reg <= 24'h000000;
        end else begin
            if (sclk_fall) begin
                din_reg <= tx_sh_reg[31];
                tx_sh_reg <= {tx_sh_reg[30:0], 1'b0};
            end
            if (sclk_rise) begin
                if (is_read && !in_comm) begin
                    rx_reg <= {rx_reg[22:0], dout_sync_reg[1]};
                end
            end
            if (rise_d_reg) begin
                bit_cnt_reg <= bit_cnt_reg + 6'h01;
            end
            if (last_rise) begin
                state_reg <= adc_port_pkg::HOST_IDLE;
            end
        end
    end

    // The host drives data only for the command byte and write data.
    wire drive = frame && (in_comm || !is_read);
    assign link.din = din_reg;
    assign link.din_oe = drive;
    assign link.transmit_frame_strobe_n = !drive;
    assign link.receive_frame_strobe_n = !(frame && is_read && !in_comm);
    // Select follows either strobe, so one line frames the whole access.
    assign link.cs_n = link.transmit_frame_strobe_n & link.receive_frame_strobe_n;
    assign o_prdata = prdata_reg;
    assign o_pready = pready_reg;
    assign o_pslverr = pslverr_reg && pready_reg;
endmodule // adc_port_host
`default_nettype wire

//--- adc_port_properties.sv
// Concurrent checks on the serial link between the host and device ends.
`timescale 1ns/1ps
`default_nettype none
module adc_port_properties (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Link signals
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic din_oe,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic receive_frame_strobe_n,
    input wire logic transmit_frame_strobe_n
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // Counts samples since the link clock last changed, saturating at the top.
    logic [7:0] run_cnt;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            run_cnt <= 8'hff;
        end else if ($changed(sclk)) begin
            run_cnt <= 8'h01;
        end else if (run_cnt != 8'hff) begin
            run_cnt <= run_cnt + 8'h01;
        end
    end
    sequence s_read_turn;
        ##[1:60] $rose(dout_oe);
    endsequence
    property p_no_dout_on_write;
        din_oe |-> !dout_oe;
    endproperty
    property p_dout_quiet;
        din_oe |-> dout == 1'b0;
    endproperty
    property p_sclk_idle;
        cs_n |-> sclk;
    endproperty
    property p_cs_strobes;
        cs_n == (receive_frame_strobe_n & transmit_frame_strobe_n);
    endproperty
    property p_sclk_rate;
        $changed(sclk) |-> run_cnt >= 8'd20;
    endproperty
    property p_din_steady;
        din_oe && sclk && $past(sclk) && !cs_n && !$past(cs_n) |-> $stable(din);
    endproperty
    property p_dout_on_fall;
        dout_oe && $past(dout_oe) && $changed(dout) |-> !sclk;
    endproperty
    property p_dout_in_read;
        dout_oe |-> !cs_n && !receive_frame_strobe_n;
    endproperty
    property p_read_turn;
        $fell(receive_frame_strobe_n) |-> s_read_turn;
    endproperty
    a_no_dout_on_write: assert property (p_no_dout_on_write)
        else $error("dout driven during write");
    a_dout_quiet: assert property (p_dout_quiet)
        else $error("dout carries data when not reading");
    a_sclk_idle: assert property (p_sclk_idle)
        else $error("sclk low outside frame");
    a_cs_strobes: assert property (p_cs_strobes)
        else $error("select not tied to strobes");
    a_sclk_rate: assert property (p_sclk_rate)
        else $error("sclk half period too short");
    a_din_steady: assert property (p_din_steady)
        else $error("din moved while sclk high");
    a_dout_on_fall: assert property (p_dout_on_fall)
        else $error("dout moved while sclk high");
    a_dout_in_read: assert property (p_dout_in_read)
        else $error("dout driven outside read");
    a_read_turn: assert property (p_read_turn)
        else $error("read data late after command");
endmodule // adc_port_properties
`default_nettype wire

//--- adc_serial_host_port_tb_top.sv
// Testbench joining host and device ends, driven over APB.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module adc_serial_host_port_tb_top;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [23:0] main_data = 24'h0;
    logic main_valid = 1'b0;
    logic [15:0] aux_data = 16'h0;
    logic aux_valid = 1'b0;
    logic [7:0] ctrl;
    logic main_rdy;
    logic aux_rdy;
    logic [31:0] rd;
    logic err;
    logic [31:0] wsh;
    logic [31:0] rsh;
    int error_cnt = 0;
    int n_checks = 0;
    always #4 i_clk = ~i_clk;
    adc_link_if link ();
    adc_port_host i_adc_port_host (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .link(link));
    adc_port_device i_adc_port_device (.i_clk(i_clk), .i_rst_b(i_rst_b), .link(link),
        .i_main_data(main_data), .i_main_valid(main_valid), .i_aux_data(aux_data),
        .i_aux_valid(aux_valid), .o_ctrl(ctrl), .o_main_ready(main_rdy),
        .o_aux_ready(aux_rdy));
    adc_port_properties i_adc_port_properties (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .sclk(link.sclk), .cs_n(link.cs_n), .din(link.din), .din_oe(link.din_oe),
        .dout(link.dout), .dout_oe(link.dout_oe),
        .receive_frame_strobe_n(link.receive_frame_strobe_n),
        .transmit_frame_strobe_n(link.transmit_frame_strobe_n));
    // Both parties sample on the rising link edge, so the wire is watched there.
    always @(posedge link.sclk) begin
        if (!link.cs_n && link.din_oe) wsh <= {wsh[30:0], link.din};
        if (!link.cs_n && link.dout_oe) rsh <= {rsh[30:0], link.shared_data};
    end
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        do @(posedge i_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // One framed transfer; the poll is bounded so a stuck busy cannot hang the run.
    task automatic xfer(input logic [7:0] comm, input logic [1:0] nb, input logic [23:0] tx);
        int k;
        wsh = 32'h0;
        rsh = 32'h0;
        apb(1'b1, adc_port_pkg::HOST_TXDATA, {8'h00, tx});
        apb(1'b1, adc_port_pkg::HOST_CMD, {15'h0, 1'b1, 6'h0, nb, comm});
        k = 0;
        do begin
            apb(1'b0, adc_port_pkg::HOST_STATUS, 32'h0);
            k++;
        end while (rd[0] !== 1'b0 && k < 4000);
        `CHK("frame done", 1'b0, rd[0])
        apb(1'b0, adc_port_pkg::HOST_RXDATA, 32'h0);
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge i_clk);
        error_cnt++;
        test_done();
    end
    initial begin
        repeat (20) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(posedge i_clk);
        `CHK("sclk idle", 1'b1, link.sclk)
        `CHK("ctrl reset", adc_port_pkg::CTRL_RESET, ctrl)
        apb(1'b0, 12'h010, 32'h0);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h0, rd)
        xfer(8'h01, 2'd1, 24'h0000a5);
        `CHK("write wire", 32'h000001a5, wsh)
        repeat (6) @(posedge i_clk);
        `CHK("ctrl written", 8'ha5, ctrl)
        xfer(8'h81, 2'd1, 24'h00003c);
        repeat (6) @(posedge i_clk);
        `CHK("ctrl kept", 8'ha5, ctrl)
        xfer(8'h41, 2'd1, 24'h0000ff);
        `CHK("ctrl read", 8'ha5, rd[7:0])
        `CHK("read wire", 32'h000000a5, rsh)
        `CHK("host drive", 32'h00000041, wsh)
        main_data <= 24'h123456;
        aux_data <= 16'hbeef;
        main_valid <= 1'b1;
        aux_valid <= 1'b1;
        @(posedge i_clk);
        main_valid <= 1'b0;
        aux_valid <= 1'b0;
        repeat (10) @(posedge i_clk);
        `CHK("ready pin", 1'b0, link.rdy_n)
        `CHK("flags", 2'b11, {aux_rdy, main_rdy})
        apb(1'b0, adc_port_pkg::HOST_STATUS, 32'h0);
        `CHK("host ready", 1'b1, rd[1])
        xfer(8'h40, 2'd1, 24'h0);
        `CHK("status both", 8'h03, rd[7:0])
        xfer(8'h42, 2'd3, 24'h0);
        `CHK("main data", 24'h123456, rd[23:0])
        `CHK("main wire", 32'h00123456, rsh)
        xfer(8'h40, 2'd1, 24'h0);
        `CHK("status aux", 8'h02, rd[7:0])
        xfer(8'h43, 2'd2, 24'h0);
        `CHK("aux data", 16'hbeef, rd[15:0])
        repeat (10) @(posedge i_clk);
        `CHK("ready idle", 1'b1, link.rdy_n)
        test_done();
    end
endmodule // adc_serial_host_port_tb_top
`default_nettype wire
